// ===== verilog/port0_gpio.sv
`timescale 1ns/1ps
`default_nettype none
module port0_gpio
  import port_gpio_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Read-modify-write qualifier
  input wire logic rmwRead,
  // Standby and peripherals
  input wire logic stopOrWatch,
  input wire logic [7:0] periphOe,
  input wire logic [7:0] periphOut,
  input wire logic [7:0] extIntEnable,
  // Pads
  input wire logic [7:0] padIn,
  output logic [7:0] padOut,
  output logic [7:0] padOe,
  output logic [7:0] pullupEn,
  // To peripherals
  output logic [7:0] digitalIn,
  output logic [7:0] external_interrupt_inputs,
  output logic cmpAPosEnable,
  output logic cmpANegEnable,
  output logic cmpBPosEnable,
  output logic cmpBNegEnable
);

  if (WIDTH != PORT_WIDTH)
  begin : g_bad_width
    $error("port0_gpio supports only eight pins");
  end

  port_state_t cur;
  port_state_t next_cur;
  logic standbyHiZ;
  logic access;
  logic [7:0] pinLevel;
  logic [7:0] dataRead;

  // ****************************************
  // Pin cells
  // ****************************************
  assign standbyHiZ = stopOrWatch & cur.pin_state_standby_bit; // see RL10 RL12

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_pin
    port_pin_cell u_cell
    (
      .latchBit(cur.port_data_latch[i]), // see RL18
      .dirBit(cur.pin_direction[i]),
      .pullBit(cur.pullup_select[i]),
      .analogDisableBit(cur.analog_input_disable_low[i]),
      .periphOe(periphOe[i]),
      .periphOut(periphOut[i]),
      .standbyHiZ(standbyHiZ),
      .extIntEnable(extIntEnable[i]),
      .padIn(padIn[i]),
      .padOut(padOut[i]),
      .padOe(padOe[i]),
      .pullupEn(pullupEn[i]),
      .digitalIn(digitalIn[i]),
      .extIntIn(external_interrupt_inputs[i])
    );
  end

  // ****************************************
  // Comparator input enables
  // ****************************************
  assign cmpAPosEnable = ~cur.comparator_control[CMP_A_INPUT_EN_N_BIT]; // see RL16
  assign cmpBPosEnable = ~cur.comparator_control[CMP_B_INPUT_EN_N_BIT]; // see RL16
  assign cmpANegEnable = ~cur.comparator_control[CMP_A_INPUT_EN_N_BIT]
    & ~cur.comparator_control[CMP_A_NEG_SEL_BIT]; // see RL17
  assign cmpBNegEnable = ~cur.comparator_control[CMP_B_INPUT_EN_N_BIT]
    & ~cur.comparator_control[CMP_B_NEG_SEL_BIT]; // see RL17

  // ****************************************
  // Data read selection
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      // Driven pins read back what is driven, inputs read digitalIn
      pinLevel[i] = padOe[i] ? padOut[i] : digitalIn[i];
      if (rmwRead)
      begin
        dataRead[i] = cur.port_data_latch[i]; // see RL6 RL7 RL20 RL23
      end
      else if (cur.pin_direction[i] & ~periphOe[i])
      begin
        dataRead[i] = cur.port_data_latch[i]; // see RL5
      end
      else
      begin
        dataRead[i] = pinLevel[i]; // see RL6 RL7 RL20
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  assign access = psel & penable;

  always_comb
  begin
    next_cur = cur;
    // Setup cycle captures read data and response for the access phase
    if (psel & ~penable)
    begin
      next_cur.slvErr = 1'b0;
      next_cur.readData = 32'h0000_0000;
      case (paddr)
        ADDR_DATA_LATCH:
        begin
          next_cur.readData = {24'h00_0000, dataRead}; // see RL5 RL6 RL23
        end
        ADDR_DIRECTION:
        begin
          next_cur.readData = {24'h00_0000, cur.pin_direction};
        end
        ADDR_PULLUP:
        begin
          next_cur.readData = {24'h00_0000, cur.pullup_select};
        end
        ADDR_ANALOG_DISABLE:
        begin
          next_cur.readData = {24'h00_0000, cur.analog_input_disable_low};
        end
        ADDR_STANDBY_CTRL:
        begin
          next_cur.readData = {31'h0000_0000, cur.pin_state_standby_bit};
        end
        ADDR_COMPARATOR_CTRL:
        begin
          next_cur.readData = {28'h000_0000, cur.comparator_control};
        end
        default:
        begin
          next_cur.slvErr = 1'b1;
        end
      endcase
    end
    // Writes land at the edge that completes the access phase
    if (access & pwrite)
    begin
      case (paddr)
        ADDR_DATA_LATCH:
        begin
          next_cur.port_data_latch = pwdata[7:0]; // see RL3 RL4
        end
        ADDR_DIRECTION:
        begin
          next_cur.pin_direction = pwdata[7:0];
        end
        ADDR_PULLUP:
        begin
          next_cur.pullup_select = pwdata[7:0];
        end
        ADDR_ANALOG_DISABLE:
        begin
          next_cur.analog_input_disable_low = pwdata[7:0];
        end
        ADDR_STANDBY_CTRL:
        begin
          next_cur.pin_state_standby_bit = pwdata[STANDBY_PIN_STATE_BIT];
        end
        ADDR_COMPARATOR_CTRL:
        begin
          next_cur.comparator_control = pwdata[3:0];
        end
        default:
        begin
          next_cur.slvErr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur.port_data_latch <= RESET_BYTE; // see RL22
      cur.pin_direction <= RESET_BYTE; // see RL9
      cur.pullup_select <= RESET_BYTE;
      cur.analog_input_disable_low <= RESET_BYTE; // see RL9
      cur.pin_state_standby_bit <= 1'b0;
      cur.comparator_control <= RESET_CMP_CTRL;
      cur.readData <= 32'h0000_0000;
      cur.slvErr <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Read data and response stand from the setup edge through the access phase
  assign pready = 1'b1;
  assign prdata = cur.readData;
  assign pslverr = access & cur.slvErr;

endmodule : port0_gpio
`default_nettype wire

// ===== inc/port_gpio_pkg.sv
// Behaviour
// RL1 - Direction one drives latch onto pin
// RL2 - Direction zero leaves pin undriven input
// RL3 - Latch write shows at once on outputs
// RL4 - Latch write on input pin stays internal
// RL5 - Output pin ordinary read returns latch
// RL6 - Input pin reads pin; RMW reads latch
// RL7 - Peripheral enable drives pin; reads as RL6
// RL8 - Analog-disable one opens digital input
// RL9 - Reset clears direction and analog-disable bits
// RL10 - Standby bit plus stop: hi-Z, input low
// RL11 - Enabled external interrupt keeps input open
// RL12 - Standby bit zero keeps pin states
// RL13 - Pull-up on by bit, off when low
// RL14 - Pin level always feeds interrupt circuit; the code forces it low in standby hi-Z unless extIntEnable is set
// RL15 - Analog use: software clears three bits
// RL16 - Noninverting comparator input on when enable-n zero
// RL17 - Inverting comparator input needs both bits zero
// RL18 - Bit n belongs to pin n
// RL19 - Software disables peripheral output before port use
// RL20 - Pin read even when peripheral inputs it
// RL21 - Digital peripheral input needs disable one, dir zero
// RL22 - Data latch resets to zero
// RL23 - Bus qualifier selects RMW read
package port_gpio_pkg;

  localparam int PORT_WIDTH = 8;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_DATA_LATCH = 12'h000;
  localparam logic [11:0] ADDR_DIRECTION = 12'h004;
  localparam logic [11:0] ADDR_PULLUP = 12'h008;
  localparam logic [11:0] ADDR_ANALOG_DISABLE = 12'h00C;
  localparam logic [11:0] ADDR_STANDBY_CTRL = 12'h010;
  localparam logic [11:0] ADDR_COMPARATOR_CTRL = 12'h014;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int STANDBY_PIN_STATE_BIT = 0;
  localparam int CMP_A_INPUT_EN_N_BIT = 0;
  localparam int CMP_A_NEG_SEL_BIT = 1;
  localparam int CMP_B_INPUT_EN_N_BIT = 2;
  localparam int CMP_B_NEG_SEL_BIT = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_CMP_CTRL = 4'hF;

  // ****************************************
  // Pin positions of comparator inputs
  // ****************************************
  localparam int PIN_CMP_A_POS = 0;
  localparam int PIN_CMP_A_NEG = 1;
  localparam int PIN_CMP_B_POS = 3;
  localparam int PIN_CMP_B_NEG = 4;

  typedef struct packed {
    logic [7:0] port_data_latch;
    logic [7:0] pin_direction;
    logic [7:0] pullup_select;
    logic [7:0] analog_input_disable_low;
    logic pin_state_standby_bit;
    logic [3:0] comparator_control;
    logic [31:0] readData;
    logic slvErr;
  } port_state_t;

  typedef struct packed {
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    logic [7:0] pullupEn;
  } pin_drive_t;

endpackage : port_gpio_pkg

// ===== verilog/port_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module port_pin_cell
(
  // Configuration
  input wire logic latchBit,
  input wire logic dirBit,
  input wire logic pullBit,
  input wire logic analogDisableBit,
  // Peripheral and standby
  input wire logic periphOe,
  input wire logic periphOut,
  input wire logic standbyHiZ,
  input wire logic extIntEnable,
  // Pad
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic pullupEn,
  output logic digitalIn,
  output logic extIntIn
);
  logic driving;

  // ****************************************
  // Output path
  // ****************************************
  always_comb
  begin
    driving = (periphOe | dirBit) & ~standbyHiZ; // see RL1 RL2 RL7 RL10 RL12
    padOut = periphOe ? periphOut : latchBit; // see RL3 RL4
    padOe = driving;
    pullupEn = pullBit & ~(driving & ~padOut); // see RL13
  end

  // ****************************************
  // Input path
  // ****************************************
  always_comb
  begin
    if (standbyHiZ & ~extIntEnable)
    begin
      digitalIn = 1'b0; // see RL10
    end
    else
    begin
      digitalIn = padIn & (analogDisableBit | standbyHiZ); // see RL8 RL11
    end
    extIntIn = (standbyHiZ & ~extIntEnable) ? 1'b0 : padIn; // see RL14 RL11
  end
endmodule : port_pin_cell
`default_nettype wire

// ===== sim/port0_gpio_props.sv
`timescale 1ns/1ps
`default_nettype none
module port0_gpio_props
  import port_gpio_pkg::*;
(
  // Bus
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins
  input wire logic stopOrWatch,
  input wire logic [7:0] periphOe,
  input wire logic [7:0] periphOut,
  input wire logic [7:0] extIntEnable,
  input wire logic [7:0] padIn,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] pullupEn,
  input wire logic [7:0] digitalIn,
  input wire logic [7:0] external_interrupt_inputs,
  input wire logic cmpAPosEnable,
  input wire logic cmpANegEnable,
  input wire logic cmpBPosEnable,
  input wire logic cmpBNegEnable
);
  // ****
  // Checks
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic mapped;
  logic [7:0] wrByte;
  assign acc = psel && penable;
  assign mapped = paddr inside {ADDR_DATA_LATCH, ADDR_DIRECTION, ADDR_PULLUP,
    ADDR_ANALOG_DISABLE, ADDR_STANDBY_CTRL, ADDR_COMPARATOR_CTRL};
  assign wrByte = pwdata[7:0];
  a_unmapped_err: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr wrong");
  a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_latch_drive: assert property (acc && pwrite && paddr == ADDR_DATA_LATCH |=>
    (padOe & ~periphOe & (padOut ^ $past(wrByte))) == 8'h00) else $error("latch not on pin");
  a_periph_drive: assert property (!stopOrWatch |->
    (periphOe & ~(padOe & ~(padOut ^ periphOut))) == 8'h00) else $error("peripheral not on pin");
  a_pullup_low: assert property ((pullupEn & padOe & ~padOut) == 8'h00)
    else $error("pull-up on low pin");
  a_extint_pass: assert property ((extIntEnable & (external_interrupt_inputs ^ padIn)) == 8'h00)
    else $error("interrupt path differs from pin");
  a_reset_state: assert property ($fell(sys_rst) |-> padOe == periphOe && digitalIn == 8'h00
    && !cmpAPosEnable && !cmpBPosEnable) else $error("state after reset wrong");
  a_cmp_neg_gate: assert property ((!cmpANegEnable || cmpAPosEnable) && (!cmpBNegEnable || cmpBPosEnable))
    else $error("inverting input enabled alone");
  a_stop_hold: assert property (stopOrWatch && $past(stopOrWatch) && !$past(acc) && $stable(periphOe)
    && $stable(periphOut) |-> $stable(padOe) && $stable(padOut)) else $error("pin moved in stop");
  c_rd: cover property (acc && !pwrite && paddr == ADDR_DATA_LATCH);
  c_hiz: cover property (stopOrWatch && padOe == 8'h00);
  c_cmp: cover property (cmpANegEnable && cmpBNegEnable);
endmodule : port0_gpio_props
bind port0_gpio port0_gpio_props i_port0_gpio_props (.*);
`default_nettype wire

// ===== sim/port_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module port_board_model
(
  // Clock
  input wire logic ref_clk,
  // Pads
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] pullupEn,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extLvl,
  output logic [7:0] padIn
);
  // ****
  // Pin levels
  // ****
  logic [7:0] flt = 8'h55;
  // Floating pins toggle so that no stale level reads as valid
  always @(posedge ref_clk) flt <= ~flt;
  assign padIn = (padOe & padOut) | (~padOe & extEn & extLvl) | (~padOe & ~extEn & (pullupEn | flt));
endmodule : port_board_model
`default_nettype wire

// ===== sim/port0_gpio_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port0_gpio_tb;
  import port_gpio_pkg::*;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, rmwRead = 0, stopOrWatch = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, cmpAPosEnable, cmpANegEnable, cmpBPosEnable, cmpBNegEnable;
  logic [7:0] periphOe = 8'h00, periphOut = 8'h00, extIntEnable = 8'h00, extEn = 8'h0F;
  logic [7:0] extLvl = 8'h03, padIn, padOut, padOe, pullupEn, digitalIn, external_interrupt_inputs;
  int nMismatch = 0, totalChecks = 0;
  logic [31:0] rdData;
  logic rdErr;
  port0_gpio i_port0_gpio (.*);
  port_board_model i_port_board_model (.*);
  // ****
  // Tasks
  // ****
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic rmw);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    rmwRead <= rmw;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 1'b0);
  endtask : wr
  task rd(input logic [11:0] a, input logic rmw, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rmw);
    chk("prdata", rdData, exp);
  endtask : rd
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  task report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // ****
  // Tests
  // ****
  initial forever #4 ref_clk = ~ref_clk;
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle();
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 1'b1, 32'h0);
    rd(ADDR_COMPARATOR_CTRL, 1'b0, 32'h0000000F);
    wr(ADDR_ANALOG_DISABLE, 8'hFF);
    wr(ADDR_DIRECTION, 8'hF0);
    wr(ADDR_DATA_LATCH, 8'hA5);
    chk("padOe", padOe, 32'h000000F0);
    chk("padOut", padOe & padOut, 32'h000000A0);
    chk("digitalIn", digitalIn & 8'h0F, 32'h00000003);
    rd(ADDR_DATA_LATCH, 1'b0, 32'h000000A3);
    rd(ADDR_DATA_LATCH, 1'b1, 32'h000000A5);
    wr(ADDR_ANALOG_DISABLE, 8'h00);
    chk("digitalIn", digitalIn, 32'h0);
    wr(ADDR_ANALOG_DISABLE, 8'hFF);
    // Peripheral takes pin 0 while its direction bit stays input
    @(posedge ref_clk);
    extEn <= 8'h0E;
    periphOe <= 8'h01;
    periphOut <= 8'h01;
    settle();
    chk("padOe", padOe, 32'h000000F1);
    chk("extInt", external_interrupt_inputs, 32'h000000A3);
    rd(ADDR_DATA_LATCH, 1'b0, 32'h000000A3);
    rd(ADDR_DATA_LATCH, 1'b1, 32'h000000A5);
    wr(ADDR_PULLUP, 8'hFF);
    chk("pullupEn", pullupEn, 32'h000000AF);
    wr(ADDR_STANDBY_CTRL, 8'h01);
    @(posedge ref_clk);
    stopOrWatch <= 1'b1;
    extIntEnable <= 8'h02;
    settle();
    chk("padOe", padOe, 32'h0);
    chk("digitalIn", digitalIn, 32'h00000002);
    chk("extInt", external_interrupt_inputs, 32'h00000002);
    @(posedge ref_clk);
    stopOrWatch <= 1'b0;
    wr(ADDR_STANDBY_CTRL, 8'h00);
    @(posedge ref_clk);
    stopOrWatch <= 1'b1;
    settle();
    chk("padOe", padOe, 32'h000000F1);
    @(posedge ref_clk);
    stopOrWatch <= 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      wr(ADDR_COMPARATOR_CTRL, 8'(k));
      chk("cmpEnables", {cmpBNegEnable, cmpBPosEnable, cmpANegEnable, cmpAPosEnable},
        {~k[3] & ~k[2], ~k[2], ~k[1] & ~k[0], ~k[0]});
    end
    rd(12'h018, 1'b0, 32'h0);
    chk("pslverr", {31'h0, rdErr}, 32'h1);
    wr(12'h018, 8'hFF);
    chk("pslverr", {31'h0, rdErr}, 32'h1);
    rd(ADDR_DIRECTION, 1'b0, 32'h000000F0);
    chk("pslverr", {31'h0, rdErr}, 32'h0);
    // Second reset in mid-run, then pins left as analog inputs
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    periphOe <= 8'h00;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle();
    rd(ADDR_DATA_LATCH, 1'b1, 32'h0);
    rd(ADDR_DIRECTION, 1'b0, 32'h0);
    rd(ADDR_ANALOG_DISABLE, 1'b0, 32'h0);
    chk("padOe", padOe, 32'h0);
    chk("pullupEn", pullupEn, 32'h0);
    chk("digitalIn", digitalIn, 32'h0);
    report_and_stop();
  end
endmodule : port0_gpio_tb
`default_nettype wire
